// *** swr_rom_layer.sv ***
// Network layer of a single-wire sensor: ROM commands, CRCs and configuration.
// What this block does
// - Config bits six/five select conversion resolution.
// - CRC x^8+x^5+x^4+1, zero start, LSB first.
// - Code top byte is CRC of low 56.
// - Ninth scratch byte is CRC, updated once a rerun over bytes 0..7 ends.
// - CRC mismatch never stops a sequence.
// - One master; this device only slave.
// - All bytes travel least significant first.
// - Drive line open-drain, release when idle.
// - Low beyond 480 us resets protocol.
// - Respond only to ordered transaction steps.
// - Reset pulse answered by presence pulse.
// - Five eight-bit ROM commands; read-code, match and skip precede functions, search ends the sequence.
// - Search finds every code by elimination.
// - Read-code sends full 64-bit code.
// - Match selects only on exact code.
// - Skip selects without a code.
// - Alarm search joins only with alarm.
// - Alarm flag follows latest conversion.
// - Reserved config bits fixed, read pattern.
// - Resolution resets to twelve bits.
// - Code: family, 48-bit serial, CRC.
// - Presence after 15-60 us, 60-240 us long.
module swr_rom_layer
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value.
    parameter logic [47:0] SERIAL_NUM = 48'h0123456789ab,
    parameter int RST_CYC = swr_pkg::RESET_LOW_CYC,
    parameter int WAIT_CYC = swr_pkg::PRES_WAIT_CYC,
    parameter int LOW_CYC = swr_pkg::PRES_LOW_CYC
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe,
    input wire swr_pkg::swr_slot_t slot,
    output swr_pkg::swr_reply_t reply,
    input wire logic alarm_update,
    input wire logic alarm_value,
    input wire logic [7:0] cfg_wr_data,
    input wire logic cfg_wr,
    input wire logic [63:0] scratch_low,
    output logic [7:0] cfg_byte,
    output logic [7:0] scratch_crc,
    output logic [63:0] rom_code,
    output logic [1:0] resolution,
    output logic func_valid,
    output logic [7:0] func_cmd,
    output logic selected,
    output logic bus_reset_pulse
);
    import swr_pkg::*;

    typedef enum logic [2:0] {ST_WAIT_RESET, ST_ROM_CMD, ST_SEND_CODE, ST_MATCH, ST_SEARCH,
                              ST_FUNC, ST_DONE} swr_st_t;

    // ------------------------------------------------------------------
    // Line watcher and CRC engines
    // ------------------------------------------------------------------
    logic bus_rst, pres_drv, pres_done;
    logic [7:0] rom_crc, scr_crc;
    logic rom_crc_clr, rom_crc_sh, scr_crc_clr, scr_crc_sh;
    logic [6:0] rom_idx_ff, nxt_rom_idx;
    logic [6:0] scr_idx_ff, nxt_scr_idx;
    logic [7:0] rom_crc_ff, nxt_rom_crc;
    logic [7:0] scr_crc_ff, nxt_scr_crc;
    logic [63:0] scr_snap_ff, nxt_scr_snap;
    logic [63:0] code_pad;

    swr_line_detect #(.RST_CYC(RST_CYC), .WAIT_CYC(WAIT_CYC), .LOW_CYC(LOW_CYC)) u_line
    (
        .core_clk(core_clk),
        .reset(reset),
        .line_in(line_in),
        .bus_reset(bus_rst),
        .presence_drive(pres_drv),
        .presence_done(pres_done)
    );

    swr_crc8 u_rom_crc
    (
        .core_clk(core_clk),
        .reset(reset),
        .clear(rom_crc_clr),
        .shift(rom_crc_sh),
        .din(code_pad[rom_idx_ff[5:0]]),
        .crc(rom_crc)
    );

    swr_crc8 u_scr_crc
    (
        .core_clk(core_clk),
        .reset(reset),
        .clear(scr_crc_clr),
        .shift(scr_crc_sh),
        .din(scr_snap_ff[scr_idx_ff[5:0]]),
        .crc(scr_crc)
    );

    // The ROM CRC is shifted over the low 56 code bits once after reset. A read
    // of the code can only follow a bus reset, which lasts far longer than this.
    logic [55:0] code_low;
    logic [63:0] code_full;
    assign code_low = {SERIAL_NUM, FAMILY_CODE};
    assign code_pad = {8'h00, code_low};
    assign code_full = {rom_crc_ff, code_low};
    assign rom_crc_clr = 1'b0;
    assign rom_crc_sh = rom_idx_ff < 7'h38;

    // ------------------------------------------------------------------
    // Scratchpad CRC: re-run over bytes 0..7 whenever they change
    // ------------------------------------------------------------------
    logic scr_busy;
    assign scr_busy = scr_idx_ff != 7'h40;
    assign scr_crc_clr = !scr_busy && (scratch_low != scr_snap_ff);
    assign scr_crc_sh = scr_busy;

    always_comb
    begin
        nxt_scr_idx = scr_idx_ff;
        nxt_scr_snap = scr_snap_ff;
        nxt_scr_crc = scr_crc_ff;
        if (scr_crc_clr)
        begin
            nxt_scr_snap = scratch_low;
            nxt_scr_idx = 7'h00;
        end
        else if (scr_busy)
        begin
            nxt_scr_idx = scr_idx_ff + 7'h01;
        end
        else
        begin
            nxt_scr_crc = scr_crc;
        end
        nxt_rom_idx = rom_idx_ff;
        nxt_rom_crc = rom_crc_ff;
        if (rom_crc_sh)
        begin
            nxt_rom_idx = rom_idx_ff + 7'h01;
        end
        else
        begin
            nxt_rom_crc = rom_crc;
        end
    end

    // ------------------------------------------------------------------
    // Configuration byte and alarm flag
    // ------------------------------------------------------------------
    logic [1:0] res_ff, nxt_res;
    logic alarm_ff, nxt_alarm;

    always_comb
    begin
        nxt_res = res_ff;
        nxt_alarm = alarm_ff;
        if (cfg_wr)
        begin
            nxt_res = {cfg_wr_data[CFG_RES_HI_BIT], cfg_wr_data[CFG_RES_LO_BIT]};
        end
        if (alarm_update)
        begin
            nxt_alarm = alarm_value;
        end
    end

    // ------------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------------
    swr_st_t st_ff, nxt_st;
    logic [7:0] sh_ff, nxt_sh;
    logic [6:0] cnt_ff, nxt_cnt;
    logic [1:0] ph_ff, nxt_ph;
    logic miss_ff, nxt_miss;
    logic sel_ff, nxt_sel;
    logic fv_ff, nxt_fv;
    logic [7:0] fc_ff, nxt_fc;
    logic rv_ff, nxt_rv;
    logic rb_ff, nxt_rb;
    logic own_bit;

    assign own_bit = code_full[cnt_ff[5:0]];

    always_comb
    begin
        nxt_st = st_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_ph = ph_ff;
        nxt_miss = miss_ff;
        nxt_sel = sel_ff;
        nxt_fv = 1'b0;
        nxt_fc = fc_ff;
        nxt_rv = 1'b0;
        nxt_rb = 1'b1;
        if (bus_rst)
        begin
            nxt_st = ST_WAIT_RESET;
            nxt_sel = 1'b0;
        end
        else
        begin
            case (st_ff)
                ST_WAIT_RESET:
                begin
                    if (pres_done)
                    begin
                        nxt_st = ST_ROM_CMD;
                        nxt_cnt = 7'h00;
                    end
                end
                ST_ROM_CMD:
                begin
                    if (slot.wr_valid)
                    begin
                        nxt_sh = {slot.wr_bit, sh_ff[7:1]};
                        nxt_cnt = cnt_ff + 7'h01;
                        if (cnt_ff == 7'h07)
                        begin
                            nxt_cnt = 7'h00;
                            nxt_ph = 2'h0;
                            nxt_miss = 1'b0;
                            case ({slot.wr_bit, sh_ff[7:1]})
                                CMD_READ_CODE: nxt_st = ST_SEND_CODE;
                                CMD_MATCH: nxt_st = ST_MATCH;
                                CMD_SKIP:
                                begin
                                    nxt_st = ST_FUNC;
                                    nxt_sel = 1'b1;
                                end
                                CMD_SEARCH: nxt_st = ST_SEARCH;
                                CMD_ALARM_SEARCH: nxt_st = alarm_ff ? ST_SEARCH : ST_DONE;
                                default: nxt_st = ST_DONE;
                            endcase
                        end
                    end
                end
                ST_SEND_CODE:
                begin
                    if (slot.rd_req)
                    begin
                        nxt_rv = 1'b1;
                        nxt_rb = own_bit;
                        nxt_cnt = cnt_ff + 7'h01;
                        if (cnt_ff == 7'h3f)
                        begin
                            nxt_st = ST_FUNC;
                            nxt_sel = 1'b1;
                            nxt_cnt = 7'h00;
                        end
                    end
                end
                ST_MATCH:
                begin
                    if (slot.wr_valid)
                    begin
                        nxt_miss = miss_ff | (slot.wr_bit != own_bit);
                        nxt_cnt = cnt_ff + 7'h01;
                        if (cnt_ff == 7'h3f)
                        begin
                            nxt_cnt = 7'h00;
                            nxt_sel = !nxt_miss;
                            nxt_st = nxt_miss ? ST_DONE : ST_FUNC;
                        end
                    end
                end
                ST_SEARCH:
                begin
                    if (ph_ff != 2'h2 && slot.rd_req)
                    begin
                        nxt_rv = 1'b1;
                        nxt_rb = (ph_ff == 2'h0) ? own_bit : !own_bit;
                        nxt_ph = ph_ff + 2'h1;
                    end
                    else if (ph_ff == 2'h2 && slot.wr_valid)
                    begin
                        nxt_ph = 2'h0;
                        nxt_cnt = cnt_ff + 7'h01;
                        if (slot.wr_bit != own_bit || cnt_ff == 7'h3f)
                        begin
                            nxt_st = ST_DONE;
                        end
                    end
                end
                ST_FUNC:
                begin
                    if (slot.wr_valid)
                    begin
                        nxt_sh = {slot.wr_bit, sh_ff[7:1]};
                        nxt_cnt = cnt_ff + 7'h01;
                        if (cnt_ff == 7'h07)
                        begin
                            nxt_fv = 1'b1;
                            nxt_fc = {slot.wr_bit, sh_ff[7:1]};
                            nxt_st = ST_DONE;
                        end
                    end
                end
                ST_DONE:
                begin
                    nxt_st = ST_DONE;
                end
                default:
                begin
                    nxt_st = ST_WAIT_RESET;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic oe_ff;
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_ff <= ST_WAIT_RESET;
            sh_ff <= 8'h00;
            cnt_ff <= 7'h00;
            ph_ff <= 2'h0;
            miss_ff <= 1'b0;
            sel_ff <= 1'b0;
            fv_ff <= 1'b0;
            fc_ff <= 8'h00;
            rv_ff <= 1'b0;
            rb_ff <= 1'b1;
            res_ff <= CFG_RES_RESET;
            alarm_ff <= 1'b0;
            scr_idx_ff <= 7'h40;
            scr_snap_ff <= 64'h0;
            scr_crc_ff <= 8'h00;
            rom_idx_ff <= 7'h00;
            rom_crc_ff <= 8'h00;
            oe_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            ph_ff <= nxt_ph;
            miss_ff <= nxt_miss;
            sel_ff <= nxt_sel;
            fv_ff <= nxt_fv;
            fc_ff <= nxt_fc;
            rv_ff <= nxt_rv;
            rb_ff <= nxt_rb;
            res_ff <= nxt_res;
            alarm_ff <= nxt_alarm;
            scr_idx_ff <= nxt_scr_idx;
            scr_snap_ff <= nxt_scr_snap;
            scr_crc_ff <= nxt_scr_crc;
            rom_idx_ff <= nxt_rom_idx;
            rom_crc_ff <= nxt_rom_crc;
            oe_ff <= pres_drv;
        end
    end

    assign line_out = 1'b0;
    assign line_oe = oe_ff;
    assign reply = '{rd_valid: rv_ff, rd_bit: rb_ff};
    assign cfg_byte = (CFG_FIXED_VAL & CFG_FIXED_MASK) | {1'b0, res_ff, 5'h00};
    assign scratch_crc = scr_crc_ff;
    assign rom_code = code_full;
    assign resolution = res_ff;
    assign func_valid = fv_ff;
    assign func_cmd = fc_ff;
    assign selected = sel_ff;
    assign bus_reset_pulse = bus_rst;

    a_reset_idle: assert property (@(posedge core_clk) disable iff (reset)
        bus_rst |=> st_ff == ST_WAIT_RESET && !sel_ff) else $error("no reset on long low");
    a_match_miss: assert property (@(posedge core_clk) disable iff (reset)
        st_ff == ST_MATCH && nxt_st == ST_DONE |=> !sel_ff) else $error("selected on mismatch");
    a_alarm_silent: assert property (@(posedge core_clk) disable iff (reset)
        st_ff == ST_ROM_CMD && slot.wr_valid && cnt_ff == 7'h07 && !alarm_ff && !bus_rst
        && {slot.wr_bit, sh_ff[7:1]} == CMD_ALARM_SEARCH |=> st_ff == ST_DONE)
        else $error("alarm search joined without alarm");
endmodule

// *** swr_pkg.sv ***
// Package of constants and types for the single-wire sensor ROM layer.
package swr_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int RESET_LOW_US = 480;
    localparam int PRES_WAIT_MIN_US = 15;
    localparam int PRES_WAIT_MAX_US = 60;
    localparam int PRES_LOW_MIN_US = 60;
    localparam int PRES_LOW_MAX_US = 240;
    localparam int PRES_WAIT_US = 30;
    localparam int PRES_LOW_US = 120;
    localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
    localparam int PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
    localparam int PRES_LOW_CYC = PRES_LOW_US * CLK_MHZ;
    localparam int CONV_TIME_MAX_US = 750000;
    localparam int CONV_9BIT_US_X100 = 9375000;

    // ------------------------------------------------------------------
    // Resolution configuration byte
    // ------------------------------------------------------------------
    localparam int CFG_RES_HI_BIT = 6;
    localparam int CFG_RES_LO_BIT = 5;
    localparam logic [7:0] CFG_FIXED_MASK = 8'h9f;
    localparam logic [7:0] CFG_FIXED_VAL = 8'h1f;
    localparam logic [1:0] CFG_RES_RESET = 2'h3;

    // ------------------------------------------------------------------
    // CRC and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
    localparam logic [7:0] CMD_SEARCH = 8'hf0;
    localparam logic [7:0] CMD_READ_CODE = 8'h33;
    localparam logic [7:0] CMD_MATCH = 8'h55;
    localparam logic [7:0] CMD_SKIP = 8'hcc;
    localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;
    localparam int CODE_BITS = 64;
    localparam int SCRATCH_BYTES = 9;

    typedef enum logic [1:0] {RES_9, RES_10, RES_11, RES_12} swr_res_t;

    // Bit-level events from the time-slot layer.
    typedef struct packed {
        logic wr_valid;
        logic wr_bit;
        logic rd_req;
    } swr_slot_t;

    // Answers from this layer to the time-slot layer.
    typedef struct packed {
        logic rd_valid;
        logic rd_bit;
    } swr_reply_t;

endpackage

// *** swr_crc8.sv ***
// Serial CRC-8 generator, x^8+x^5+x^4+1, fed least significant bit first.
module swr_crc8
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic shift,
    input wire logic din,
    output logic [7:0] crc
);
    import swr_pkg::*;

    logic [7:0] crc_ff;
    logic [7:0] nxt_crc;

    always_comb
    begin
        nxt_crc = crc_ff;
        if (clear)
        begin
            nxt_crc = 8'h00;
        end
        else if (shift)
        begin
            nxt_crc = {1'b0, crc_ff[7:1]} ^ ((crc_ff[0] ^ din) ? CRC_POLY_REFL : 8'h00);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            crc_ff <= 8'h00;
        end
        else
        begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc = crc_ff;

    a_crc_clear: assert property (@(posedge core_clk) disable iff (reset)
        clear |=> crc_ff == 8'h00) else $error("crc not cleared");
endmodule

// *** swr_line_detect.sv ***
// Line watcher: long-low reset detection and presence pulse timing.
module swr_line_detect
#(
    parameter int RST_CYC = swr_pkg::RESET_LOW_CYC,
    parameter int WAIT_CYC = swr_pkg::PRES_WAIT_CYC,
    parameter int LOW_CYC = swr_pkg::PRES_LOW_CYC
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic line_in,
    output logic bus_reset,
    output logic presence_drive,
    output logic presence_done
);
    import swr_pkg::*;

    typedef enum logic [1:0] {LD_IDLE, LD_WAIT, LD_PULSE} swr_ld_t;

    swr_ld_t st_ff, nxt_st;
    logic [19:0] low_cnt_ff, nxt_low_cnt;
    logic [15:0] tm_ff, nxt_tm;
    logic long_ff, nxt_long;
    logic rst_ff, nxt_rst;
    logic drv_ff, nxt_drv;
    logic done_ff, nxt_done;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_low_cnt = low_cnt_ff;
        nxt_tm = tm_ff;
        nxt_long = long_ff;
        nxt_rst = 1'b0;
        nxt_drv = 1'b0;
        nxt_done = 1'b0;
        if (!line_in && !drv_ff)
        begin
            if (low_cnt_ff < 20'(RST_CYC))
            begin
                nxt_low_cnt = low_cnt_ff + 20'h00001;
            end
            else
            begin
                nxt_long = 1'b1;
                nxt_rst = !long_ff;
            end
        end
        else if (line_in)
        begin
            nxt_low_cnt = 20'h00000;
            nxt_long = 1'b0;
        end
        case (st_ff)
            LD_IDLE:
            begin
                if (long_ff && line_in)
                begin
                    nxt_st = LD_WAIT;
                    nxt_tm = 16'h0000;
                end
            end
            LD_WAIT:
            begin
                nxt_tm = tm_ff + 16'h0001;
                if (tm_ff == 16'(WAIT_CYC - 1))
                begin
                    nxt_st = LD_PULSE;
                    nxt_tm = 16'h0000;
                    nxt_drv = 1'b1;
                end
            end
            LD_PULSE:
            begin
                nxt_tm = tm_ff + 16'h0001;
                nxt_drv = 1'b1;
                if (tm_ff == 16'(LOW_CYC - 1))
                begin
                    nxt_st = LD_IDLE;
                    nxt_drv = 1'b0;
                    nxt_done = 1'b1;
                end
            end
            default:
            begin
                nxt_st = LD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_ff <= LD_IDLE;
            low_cnt_ff <= 20'h00000;
            tm_ff <= 16'h0000;
            long_ff <= 1'b0;
            rst_ff <= 1'b0;
            drv_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            low_cnt_ff <= nxt_low_cnt;
            tm_ff <= nxt_tm;
            long_ff <= nxt_long;
            rst_ff <= nxt_rst;
            drv_ff <= nxt_drv;
            done_ff <= nxt_done;
        end
    end

    assign bus_reset = rst_ff;
    assign presence_drive = drv_ff;
    assign presence_done = done_ff;

    sequence s_pres_start;
        $rose(drv_ff);
    endsequence
    a_pres_width: assert property (@(posedge core_clk) disable iff (reset)
        s_pres_start |-> drv_ff [*8]) else $error("presence pulse too short");
    a_reset_cause: assert property (@(posedge core_clk) disable iff (reset)
        rst_ff |-> $past(low_cnt_ff) == 20'(RST_CYC)) else $error("reset without long low");
endmodule

// *** swr_master_model.sv ***
// Behavioural bus master: drives the pulled-up line and raises time-slot events.
module swr_master_model
#(
    parameter int RST_CYC = swr_pkg::RESET_LOW_CYC
)
(
    input wire logic core_clk,
    input wire logic line_oe,
    input wire swr_pkg::swr_reply_t reply,
    output logic line_in,
    output swr_pkg::swr_slot_t slot
);
    timeunit 1ns;
    timeprecision 1ps;
    import swr_pkg::*;

    logic m_low = 1'b0;
    int wait_cyc;
    int low_cyc;

    // The line is low while either party pulls it, otherwise the pull-up wins.
    assign line_in = ~(m_low | line_oe);
    initial slot = '0;

    // ------------------------------------------------------------------
    // Transaction steps
    // ------------------------------------------------------------------
    task automatic bus_init();
        int n;
        @(negedge core_clk);
        m_low = 1'b1;
        repeat (RST_CYC + 20) @(negedge core_clk);
        m_low = 1'b0;
        n = 0;
        while (!line_oe && n < 50000)
        begin
            @(negedge core_clk);
            n++;
        end
        wait_cyc = n;
        n = 0;
        while (line_oe && n < 100000)
        begin
            @(negedge core_clk);
            n++;
        end
        low_cyc = n;
        // The line rests released and high between steps.
        repeat (20) @(negedge core_clk);
    endtask

    task automatic put_bit(input logic b);
        @(negedge core_clk);
        slot.wr_valid = 1'b1;
        slot.wr_bit = b;
        @(negedge core_clk);
        slot.wr_valid = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask

    task automatic put_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) put_bit(v[i]);
    endtask

    // A slot with no reply reads as the pulled-up level.
    task automatic get_bit(output logic b);
        logic got;
        @(negedge core_clk);
        slot.rd_req = 1'b1;
        @(negedge core_clk);
        slot.rd_req = 1'b0;
        b = 1'b1;
        got = 1'b0;
        for (int n = 0; n < 3; n++)
        begin
            if (!got && reply.rd_valid === 1'b1)
            begin
                b = reply.rd_bit;
                got = 1'b1;
            end
            @(negedge core_clk);
        end
    endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the single-wire sensor ROM layer.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import swr_pkg::*;

    localparam logic [7:0] FAM = 8'h3c; // Arbitrary value.
    localparam logic [47:0] SER = 48'ha1b2c3d4e5f6;
    // Reset and presence times are cut a hundredfold to keep the run short.
    localparam int SCALE = 100;
    localparam int WAIT_LO = PRES_WAIT_MIN_US * CLK_MHZ / SCALE;
    localparam int WAIT_HI = PRES_WAIT_MAX_US * CLK_MHZ / SCALE;
    localparam int LOW_LO = PRES_LOW_MIN_US * CLK_MHZ / SCALE;
    localparam int LOW_HI = PRES_LOW_MAX_US * CLK_MHZ / SCALE;
    logic core_clk = 1'b0;
    logic reset, line_in, line_out, line_oe;
    swr_slot_t slot;
    swr_reply_t reply;
    logic alarm_update, alarm_value, cfg_wr, func_valid, selected, bus_reset_pulse, bit_seen;
    logic [7:0] cfg_wr_data, cfg_byte, scratch_crc, func_cmd, fc_last;
    logic [63:0] scratch_low, rom_code, exp_code, code, comp;
    logic [1:0] resolution;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int fv_cnt = 0;
    int rst_cnt = 0;

    always #2.5 core_clk = ~core_clk;

    swr_rom_layer #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .RST_CYC(RESET_LOW_CYC / SCALE),
        .WAIT_CYC(PRES_WAIT_CYC / SCALE), .LOW_CYC(PRES_LOW_CYC / SCALE)) i_swr_rom_layer (.core_clk(core_clk),
        .reset(reset), .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .slot(slot), .reply(reply),
        .alarm_update(alarm_update), .alarm_value(alarm_value), .cfg_wr_data(cfg_wr_data), .cfg_wr(cfg_wr),
        .scratch_low(scratch_low), .cfg_byte(cfg_byte), .scratch_crc(scratch_crc), .rom_code(rom_code),
        .resolution(resolution), .func_valid(func_valid), .func_cmd(func_cmd), .selected(selected),
        .bus_reset_pulse(bus_reset_pulse));
    swr_master_model #(.RST_CYC(RESET_LOW_CYC / SCALE)) i_swr_master_model (.core_clk(core_clk), .line_oe(line_oe),
        .reply(reply),
        .line_in(line_in), .slot(slot));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] crc_bits(input logic [63:0] d, input int nb);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < nb; i++) c = (c >> 1) ^ (((c[0] ^ d[i]) == 1'b1) ? CRC_POLY_REFL : 8'h00);
        return c;
    endfunction

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (func_valid === 1'b1)
        begin
            fv_cnt++;
            fc_last = func_cmd;
        end
        if (bus_reset_pulse === 1'b1) rst_cnt++;
        if (cyc == 30000)
        begin
            error_cnt++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        alarm_update = 1'b0;
        alarm_value = 1'b1;
        cfg_wr = 1'b0;
        cfg_wr_data = 8'h00;
        scratch_low = 64'h0;
        exp_code = {crc_bits({8'h00, SER, FAM}, 56), SER, FAM};
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        chk("cfg_byte", 8'h7f, cfg_byte);
        chk("resolution", 2'h3, resolution);
        for (int r = 0; r < 4; r++)
        begin
            cfg_wr_data = {1'b1, 2'(r), 5'h00};
            cfg_wr = 1'b1;
            @(negedge core_clk);
            cfg_wr = 1'b0;
            @(negedge core_clk);
            chk("cfg_byte", {1'b0, 2'(r), 5'h1f}, cfg_byte);
            chk("resolution", 64'(r), resolution);
        end
        for (int k = 0; k < 2; k++)
        begin
            scratch_low = (k == 0) ? 64'h10ff_ff7f_4b46_0550 : 64'h1000_ff1f_0a14_0191;
            repeat (100) @(negedge core_clk);
            chk("scratch_crc", crc_bits(scratch_low, 64), scratch_crc);
        end
        alarm_update = 1'b1;
        @(negedge core_clk);
        alarm_update = 1'b0;
        i_swr_master_model.put_byte(CMD_SKIP);
        chk("selected", 1'b0, selected);
        i_swr_master_model.bus_init();
        chk("bus_reset", 1, rst_cnt);
        chk("pres_wait", 1, i_swr_master_model.wait_cyc inside {[WAIT_LO:WAIT_HI]});
        chk("pres_low", 1, i_swr_master_model.low_cyc inside {[LOW_LO:LOW_HI]});
        i_swr_master_model.put_byte(CMD_READ_CODE);
        for (int i = 0; i < 64; i++) i_swr_master_model.get_bit(code[i]);
        chk("rom_code_wire", exp_code, code);
        chk("rom_code", exp_code, rom_code);
        chk("crc_remainder", 8'h00, crc_bits(code, 64));
        i_swr_master_model.bus_init();
        i_swr_master_model.put_byte(CMD_MATCH);
        for (int i = 0; i < 64; i++) i_swr_master_model.put_bit(exp_code[i]);
        chk("selected", 1'b1, selected);
        i_swr_master_model.put_byte(8'hbe);
        repeat (5) @(negedge core_clk);
        chk("func_count", 1, fv_cnt);
        chk("func_cmd", 8'hbe, fc_last);
        i_swr_master_model.bus_init();
        i_swr_master_model.put_byte(CMD_ALARM_SEARCH);
        for (int i = 0; i < 64; i++)
        begin
            i_swr_master_model.get_bit(code[i]);
            i_swr_master_model.get_bit(comp[i]);
            i_swr_master_model.put_bit(exp_code[i]);
        end
        chk("search_code", exp_code, code);
        chk("search_comp", ~exp_code, comp);
        i_swr_master_model.put_byte(8'h44);
        alarm_value = 1'b0;
        alarm_update = 1'b1;
        @(negedge core_clk);
        alarm_update = 1'b0;
        i_swr_master_model.bus_init();
        i_swr_master_model.put_byte(CMD_ALARM_SEARCH);
        i_swr_master_model.get_bit(bit_seen);
        chk("alarm_silent", 1'b1, bit_seen);
        i_swr_master_model.bus_init();
        i_swr_master_model.put_byte(CMD_MATCH);
        for (int i = 0; i < 64; i++) i_swr_master_model.put_bit(exp_code[i] ^ (i == 40));
        chk("selected", 1'b0, selected);
        i_swr_master_model.put_byte(8'h44);
        i_swr_master_model.bus_init();
        i_swr_master_model.put_byte(CMD_SKIP);
        chk("selected", 1'b1, selected);
        i_swr_master_model.put_byte(8'hbe);
        repeat (5) @(negedge core_clk);
        chk("func_count", 2, fv_cnt);
        chk("bus_reset", 6, rst_cnt);
        final_report();
    end
endmodule
